/* pkg/fcs_pkg.sv */
package fcs_pkg;
	// Clock and times
	localparam int CLK_MHZ        = 10;
	localparam int INIT_DLY_US    = 50;
	localparam int SLAVE_WAIT_US  = 250;
	localparam int POR_MS         = 16;
	localparam int INIT_DLY_CYC   = INIT_DLY_US * CLK_MHZ;
	localparam int SLAVE_WAIT_CYC = SLAVE_WAIT_US * CLK_MHZ;
	localparam int POR_CYC        = POR_MS * 1000 * CLK_MHZ;
	localparam int MODE_SETTLE    = 2;
	// Array geometry
	localparam int FRAMES         = 16;
	localparam int FRAME_BITS     = 16;
	localparam int LEN_BITS       = 24;
	localparam int ERR_BITS       = 4;
	localparam int RATE_BIT_IDX   = 2;
	localparam int FAST_FACTOR    = 8;
	localparam int SLOW_HALF_CYC  = 40;
	localparam int FAST_HALF_CYC  = SLOW_HALF_CYC / FAST_FACTOR;
	localparam logic [3:0] PREAMBLE  = 4'h2;
	localparam logic [3:0] ERR_FIELD = 4'h6;
	// Input synchroniser slots
	localparam int NSYNC    = 6;
	localparam int S_PROG   = 0;
	localparam int S_INIT   = 1;
	localparam int S_DONE   = 2;
	localparam int S_CFG_CLOCK   = 3;
	localparam int S_UCLK   = 4;
	localparam int S_DIN    = 5;
	// Registers
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_LENGTH = 12'h008;
	localparam logic [11:0] OFS_COUNT  = 12'h00C;
	localparam int CTL_DONE_TAP = 0;
	localparam int CTL_IO_TAP   = 2;
	localparam int CTL_GSR_TAP  = 4;
	localparam int CTL_USERCLK  = 6;
	localparam int CTL_SYNCDONE = 7;
	localparam logic [7:0] CTRL_RST = 8'h24;
	typedef enum {
		ST_CLEAR, ST_LAST_CLEAR, ST_INIT_WAIT, ST_INIT_DELAY, ST_MODE, ST_SETTLE,
		ST_CONFIG, ST_ERROR, ST_STARTUP
	} fcs_state_t;
	typedef enum {PH_HEAD, PH_LEN, PH_START, PH_DATA, PH_ERR, PH_DONE} fcs_phase_t;
endpackage

/* hdl/fcs_startup_ctrl.sv */
`timescale 1ns/1ps
// Behaviour
// - Stay in memory clear while power-on delay runs or program is low.
// - After each clear pass, if both idle, clear once more then test hold pin.
// - Low-during-cfg and done low, high-during-cfg high until configured; hold low while clearing.
// - Release hold pin after last pass; master waits 50 us after seeing it high.
// - Two clocks after hold pin high, sample the three mode lines.
// - Preamble 0010 then 24-bit length count, captured as clock total.
// - After preamble and length pass on, hold chain output high.
// - Master runs slow clock until rate bit; fast rate is eight times faster.
// - Frame error stops loading and pulls hold pin low.
// - After own frames, chain output follows incoming data again.
// - Program low keeps clearing; on rise clear once more, then configure.
// - Program low forces hold output low.
// - External low on hold pin delays configuration until released.
// - Master waits a further 250 us after hold pin release.
// - Done, I/O activation and set/reset release ordered by selectable taps.
// - Default: done, then I/O one clock later, then set/reset.
// - Later stages clocked by configuration clock or user wake-up clock.
// - In done-synced modes an external low on done stalls start-up.
// - Start-up begins at memory full with count equal to length.
// - Next clock sets stage 0 of a 5-bit shift register; taps drive events.
// - Done line feeds stage 3 only in synced modes.
// - Clock counter counts from the very first configuration clock.
// - On mismatch master keeps clocking until counter wraps and matches.
module fcs_startup_ctrl #(
	parameter int POR_CYC = fcs_pkg::POR_CYC
) (
	input  wire logic        CLOCK,
	input  wire logic        NRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        PROGRAM_N,
	input  wire logic [2:0]  MODE,
	input  wire logic        INIT_N_I,
	output logic             INIT_N_O,
	output logic             INIT_N_OE_N,
	input  wire logic        DONE_I,
	output logic             DONE_O,
	output logic             DONE_OE_N,
	input  wire logic        CFG_CLOCK_I,
	output logic             CFG_CLOCK_O,
	output logic             CFG_CLOCK_OE_N,
	input  wire logic        USER_WAKEUP_CLOCK,
	input  wire logic        DIN,
	output logic             DOUT,
	output logic             HIGH_DURING_CFG,
	output logic             LOW_DURING_CFG_N,
	output logic             IO_ACTIVE,
	output logic             GSR_ACTIVE
);
	// Pin synchronisers: three stages, a change counts when stages two and three agree
	logic [fcs_pkg::NSYNC-1:0] s1_q, s2_q, s3_q, flt_q;
	logic [fcs_pkg::NSYNC-1:0] pins;
	assign pins = {DIN, USER_WAKEUP_CLOCK, CFG_CLOCK_I, DONE_I, INIT_N_I, PROGRAM_N};
	genvar gi;
	generate
		for (gi = 0; gi < fcs_pkg::NSYNC; gi++) begin : g_sync
			always_ff @(posedge CLOCK or negedge NRST) begin
				if (!NRST) begin
					s1_q[gi]  <= 1'b1;
					s2_q[gi]  <= 1'b1;
					s3_q[gi]  <= 1'b1;
					flt_q[gi] <= 1'b1;
				end else begin
					s1_q[gi] <= pins[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) flt_q[gi] <= s3_q[gi];
				end
			end
		end
	endgenerate

	logic prog_n, init_in, done_in, din;
	assign prog_n  = flt_q[fcs_pkg::S_PROG];
	assign init_in = flt_q[fcs_pkg::S_INIT];
	assign done_in = flt_q[fcs_pkg::S_DONE];
	assign din     = flt_q[fcs_pkg::S_DIN];

	// Edge finders on filtered clocks
	logic cfg_clock_old_q, uclk_old_q;
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			cfg_clock_old_q <= 1'b1;
			uclk_old_q <= 1'b1;
		end else begin
			cfg_clock_old_q <= flt_q[fcs_pkg::S_CFG_CLOCK];
			uclk_old_q <= flt_q[fcs_pkg::S_UCLK];
		end
	end

	fcs_pkg::fcs_state_t state_q, state_d;
	fcs_pkg::fcs_phase_t phase_q;
	logic [23:0] por_q;
	logic [15:0] dly_q;
	logic [7:0]  addr_q;
	logic        master_q;
	logic [2:0]  mode_q;
	logic        fast_q;
	logic [7:0]  div_q;
	logic        cfg_clock_q;
	logic [23:0] len_q, cnt_q;
	logic [3:0]  hdr_q;
	logic [7:0]  bit_q;
	logic [7:0]  frm_q;
	logic        err_q;
	logic        dout_q;
	logic [4:0]  st_q;
	logic [7:0]  ctrl_q;

	logic por_busy, pass_end, mem_full, len_match, run_clk;
	logic mst_tick, slv_tick, cfg_tick, usr_tick, stage_tick;
	logic [7:0] half_cyc;
	assign por_busy  = (por_q != 24'h000000);
	assign pass_end  = (addr_q == 8'(fcs_pkg::FRAMES - 1));
	assign mem_full  = (frm_q == 8'(fcs_pkg::FRAMES));
	assign len_match = mem_full && (cnt_q == len_q);
	// Master keeps clocking past memory full until start-up ends
	assign run_clk   = master_q && (state_q == fcs_pkg::ST_CONFIG
		|| state_q == fcs_pkg::ST_STARTUP) && !st_q[4];
	assign half_cyc  = fast_q ? 8'(fcs_pkg::FAST_HALF_CYC) : 8'(fcs_pkg::SLOW_HALF_CYC);
	assign mst_tick  = run_clk && !cfg_clock_q && (div_q == half_cyc - 8'h01);
	assign slv_tick  = !master_q && flt_q[fcs_pkg::S_CFG_CLOCK] && !cfg_clock_old_q;
	assign cfg_tick  = mst_tick || slv_tick;
	assign usr_tick  = flt_q[fcs_pkg::S_UCLK] && !uclk_old_q;
	assign stage_tick = ctrl_q[fcs_pkg::CTL_USERCLK] ? usr_tick : cfg_tick;

	// Sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			fcs_pkg::ST_CLEAR: begin
				if (pass_end && !por_busy && prog_n) state_d = fcs_pkg::ST_LAST_CLEAR;
			end
			fcs_pkg::ST_LAST_CLEAR: begin
				if (pass_end) state_d = fcs_pkg::ST_INIT_WAIT;
			end
			fcs_pkg::ST_INIT_WAIT: begin
				if (init_in) state_d = master_q ? fcs_pkg::ST_INIT_DELAY : fcs_pkg::ST_MODE;
			end
			fcs_pkg::ST_INIT_DELAY: begin
				if (!init_in) state_d = fcs_pkg::ST_INIT_WAIT;
				else if (dly_q == 16'(fcs_pkg::INIT_DLY_CYC - 1)) state_d = fcs_pkg::ST_MODE;
			end
			fcs_pkg::ST_MODE: begin
				if (dly_q == 16'(fcs_pkg::MODE_SETTLE - 1)) state_d = fcs_pkg::ST_SETTLE;
			end
			fcs_pkg::ST_SETTLE: begin
				if (!master_q || dly_q == 16'(fcs_pkg::SLAVE_WAIT_CYC - 1))
					state_d = fcs_pkg::ST_CONFIG;
			end
			fcs_pkg::ST_CONFIG: begin
				if (err_q) state_d = fcs_pkg::ST_ERROR;
				else if (len_match) state_d = fcs_pkg::ST_STARTUP;
			end
			fcs_pkg::ST_ERROR: state_d = fcs_pkg::ST_ERROR;
			fcs_pkg::ST_STARTUP: state_d = fcs_pkg::ST_STARTUP;
		endcase
		if (!prog_n) state_d = fcs_pkg::ST_CLEAR;
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) state_q <= fcs_pkg::ST_CLEAR;
		else state_q <= state_d;
	end

	// Power-on delay runs once after reset only
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) por_q <= 24'(POR_CYC);
		else if (por_busy) por_q <= por_q - 24'h000001;
	end

	// Frame clearing at one frame per internal clock
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) addr_q <= 8'h00;
		else if (state_q == fcs_pkg::ST_CLEAR || state_q == fcs_pkg::ST_LAST_CLEAR)
			addr_q <= pass_end ? 8'h00 : addr_q + 8'h01;
		else addr_q <= 8'h00;
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) dly_q <= 16'h0000;
		else if (state_d != state_q) dly_q <= 16'h0000;
		else dly_q <= dly_q + 16'h0001;
	end

	// Mode capture; mode bit 0 low selects master
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			mode_q   <= 3'h7;
			master_q <= 1'b0;
		end else if (state_q == fcs_pkg::ST_MODE && state_d == fcs_pkg::ST_SETTLE) begin
			mode_q   <= MODE;
			master_q <= ~MODE[0];
		end
	end

	// Master clock divider
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			div_q  <= 8'h00;
			cfg_clock_q <= 1'b0;
		end else if (!run_clk) begin
			div_q  <= 8'h00;
			cfg_clock_q <= 1'b0;
		end else if (div_q >= half_cyc - 8'h01) begin
			div_q  <= 8'h00;
			cfg_clock_q <= ~cfg_clock_q;
		end else div_q <= div_q + 8'h01;
	end

	// Bitstream parser, one bit per configuration clock
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			phase_q <= fcs_pkg::PH_HEAD;
			hdr_q   <= 4'hF;
			len_q   <= 24'h000000;
			cnt_q   <= 24'h000000;
			bit_q   <= 8'h00;
			frm_q   <= 8'h00;
			err_q   <= 1'b0;
			fast_q  <= 1'b0;
		end else if (state_q != fcs_pkg::ST_CONFIG && state_q != fcs_pkg::ST_STARTUP) begin
			phase_q <= fcs_pkg::PH_HEAD;
			hdr_q   <= 4'hF;
			cnt_q   <= 24'h000000;
			bit_q   <= 8'h00;
			frm_q   <= 8'h00;
			fast_q  <= 1'b0;
			if (state_q != fcs_pkg::ST_ERROR) err_q <= 1'b0;
		end else if (cfg_tick && state_q == fcs_pkg::ST_CONFIG) begin
			cnt_q <= cnt_q + 24'h000001;
			unique case (phase_q)
				fcs_pkg::PH_HEAD: begin
					hdr_q <= {hdr_q[2:0], din};
					if ({hdr_q[2:0], din} == fcs_pkg::PREAMBLE) phase_q <= fcs_pkg::PH_LEN;
				end
				fcs_pkg::PH_LEN: begin
					len_q <= {len_q[22:0], din};
					bit_q <= bit_q + 8'h01;
					if (bit_q == 8'(fcs_pkg::LEN_BITS - 1)) begin
						bit_q   <= 8'h00;
						phase_q <= fcs_pkg::PH_START;
					end
				end
				fcs_pkg::PH_START: begin
					if (!din) phase_q <= fcs_pkg::PH_DATA;
				end
				fcs_pkg::PH_DATA: begin
					if (frm_q == 8'h00 && bit_q == 8'(fcs_pkg::RATE_BIT_IDX))
						fast_q <= din;
					bit_q <= bit_q + 8'h01;
					if (bit_q == 8'(fcs_pkg::FRAME_BITS - 1)) begin
						bit_q   <= 8'h00;
						phase_q <= fcs_pkg::PH_ERR;
					end
				end
				fcs_pkg::PH_ERR: begin
					hdr_q <= {hdr_q[2:0], din};
					bit_q <= bit_q + 8'h01;
					if (bit_q == 8'(fcs_pkg::ERR_BITS - 1)) begin
						bit_q <= 8'h00;
						if ({hdr_q[2:0], din} != fcs_pkg::ERR_FIELD) err_q <= 1'b1;
						frm_q   <= frm_q + 8'h01;
						phase_q <= (frm_q == 8'(fcs_pkg::FRAMES - 1)) ?
							fcs_pkg::PH_DONE : fcs_pkg::PH_START;
					end
				end
				fcs_pkg::PH_DONE: phase_q <= fcs_pkg::PH_DONE;
			endcase
		end
	end

	// Chain output: pass header, block own frames, then pass the rest
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) dout_q <= 1'b1;
		else if (phase_q == fcs_pkg::PH_HEAD || phase_q == fcs_pkg::PH_LEN
			|| phase_q == fcs_pkg::PH_DONE) dout_q <= din;
		else dout_q <= 1'b1;
	end

	// Start-up shift register; done gates stage 3 only when synced
	logic done_gate;
	assign done_gate = !ctrl_q[fcs_pkg::CTL_SYNCDONE] || done_in;
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) st_q <= 5'h00;
		else if (state_q != fcs_pkg::ST_STARTUP) st_q <= 5'h00;
		else begin
			if (cfg_tick) st_q[0] <= 1'b1;
			if (stage_tick) begin
				st_q[1] <= st_q[0];
				st_q[2] <= st_q[1];
				st_q[3] <= st_q[2] & done_gate;
				st_q[4] <= st_q[3];
			end
		end
	end

	// Tap field selects stage 1..4
	function automatic logic tap(input logic [4:0] s, input logic [1:0] sel);
		tap = s[3'(sel) + 3'h1];
	endfunction
	logic done_rel, io_on, gsr_off;
	assign done_rel = tap(st_q, ctrl_q[fcs_pkg::CTL_DONE_TAP +: 2]);
	assign io_on    = tap(st_q, ctrl_q[fcs_pkg::CTL_IO_TAP +: 2]);
	assign gsr_off  = tap(st_q, ctrl_q[fcs_pkg::CTL_GSR_TAP +: 2]);

	// Pin drive; open-drain outputs only ever pull low
	logic init_pull;
	assign init_pull = !prog_n || state_q == fcs_pkg::ST_CLEAR
		|| state_q == fcs_pkg::ST_LAST_CLEAR || state_q == fcs_pkg::ST_ERROR;
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			INIT_N_OE_N      <= 1'b0;
			DONE_OE_N        <= 1'b0;
			HIGH_DURING_CFG  <= 1'b1;
			LOW_DURING_CFG_N <= 1'b0;
			IO_ACTIVE        <= 1'b0;
			GSR_ACTIVE       <= 1'b1;
			CFG_CLOCK_OE_N   <= 1'b1;
			CFG_CLOCK_O      <= 1'b0;
			DOUT             <= 1'b1;
		end else begin
			INIT_N_OE_N      <= !init_pull;
			DONE_OE_N        <= done_rel;
			HIGH_DURING_CFG  <= !done_rel;
			LOW_DURING_CFG_N <= done_rel;
			IO_ACTIVE        <= io_on;
			GSR_ACTIVE       <= !gsr_off;
			CFG_CLOCK_OE_N   <= !(master_q && (state_q == fcs_pkg::ST_CONFIG
				|| state_q == fcs_pkg::ST_STARTUP));
			CFG_CLOCK_O      <= cfg_clock_q;
			DOUT             <= dout_q;
		end
	end
	assign INIT_N_O = 1'b0;
	assign DONE_O   = 1'b0;

	// APB slave: zero wait states, read data latched in the setup cycle
	logic        setup, wr_en, hit;
	logic [31:0] rdata;
	assign setup = PSEL && !PENABLE;
	assign hit   = PADDR == fcs_pkg::OFS_CTRL || PADDR == fcs_pkg::OFS_STATUS
		|| PADDR == fcs_pkg::OFS_LENGTH || PADDR == fcs_pkg::OFS_COUNT;
	assign wr_en = PSEL && PENABLE && PWRITE && PADDR == fcs_pkg::OFS_CTRL;
	assign rdata = (PADDR == fcs_pkg::OFS_CTRL)   ? {24'h000000, ctrl_q} :
		(PADDR == fcs_pkg::OFS_STATUS) ? {12'h000, st_q, mode_q, master_q, fast_q,
			err_q, mem_full, 4'(state_q), 4'(phase_q)} :
		(PADDR == fcs_pkg::OFS_LENGTH) ? {8'h00, len_q} :
		(PADDR == fcs_pkg::OFS_COUNT)  ? {8'h00, cnt_q} : 32'h00000000;
	assign PREADY = 1'b1;
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			PRDATA  <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else if (setup) begin
			PRDATA  <= PWRITE ? 32'h00000000 : rdata;
			PSLVERR <= !hit;
		end
	end
	// Option changes land in any state but start-up to keep start-up coherent
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) ctrl_q <= fcs_pkg::CTRL_RST;
		else if (wr_en && state_q != fcs_pkg::ST_STARTUP) ctrl_q <= PWDATA[7:0];
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);

	sequence s_start;
		state_q == fcs_pkg::ST_STARTUP && cfg_tick && !st_q[0];
	endsequence
	sequence s_default_opts;
		ctrl_q == fcs_pkg::CTRL_RST;
	endsequence

	a_prog_holds_init: assert property (!prog_n |-> ##1 !INIT_N_OE_N)
		else $error("Hold pin not driven low while program is low");
	a_stage_clear: assert property (state_q != fcs_pkg::ST_STARTUP |-> ##1 st_q == 5'h00)
		else $error("Start-up register not clear before start");
	a_stage0_set: assert property (s_start |-> ##1 st_q[0])
		else $error("Stage 0 not set on clock after start condition");
	a_start_cond: assert property (state_q == fcs_pkg::ST_CONFIG
		&& state_d == fcs_pkg::ST_STARTUP |-> mem_full && cnt_q == len_q)
		else $error("Start-up entered without full memory and length match");
	a_dout_held: assert property (phase_q == fcs_pkg::PH_DATA ##1 1'b1 |-> ##1 DOUT)
		else $error("Chain output not held high during own frames");
	a_err_init: assert property ($rose(err_q) |-> ##[1:2] !INIT_N_OE_N)
		else $error("Frame error did not pull hold pin low");
	a_status_pins: assert property (!done_rel |-> ##1 HIGH_DURING_CFG && !LOW_DURING_CFG_N
		&& !DONE_OE_N)
		else $error("Status outputs wrong during configuration");
	a_default_order: assert property (s_default_opts ##0 $rose(done_rel)
		|-> !io_on && !gsr_off)
		else $error("Default order violated: done not first");
	a_mode_sample: assert property (state_q == fcs_pkg::ST_MODE && state_d == fcs_pkg::ST_SETTLE
		|-> dly_q == 16'(fcs_pkg::MODE_SETTLE - 1) ##1 mode_q == $past(MODE))
		else $error("Mode lines not sampled two clocks after hold high");
	a_sync_stall: assert property (ctrl_q[fcs_pkg::CTL_SYNCDONE] && !done_in && !st_q[3]
		&& state_q == fcs_pkg::ST_STARTUP |-> ##1 !st_q[3])
		else $error("Start-up passed stage 3 with done held low");
endmodule // fcs_startup_ctrl

/* bench/fcs_cfg_source.sv */
`timescale 1ns/1ps
// Serial bitstream source plus the pulled-up open-drain hold and done wires
module fcs_cfg_source (
	input  wire logic init_oe_n,
	input  wire logic init_o,
	input  wire logic done_oe_n,
	input  wire logic done_o,
	output logic      init_line,
	output logic      done_line,
	output logic      cfg_clk,
	output logic      din,
	output int        ticks
);
	logic hold_init_n;
	logic hold_done_n;
	assign init_line = (init_oe_n | init_o) & hold_init_n;
	assign done_line = (done_oe_n | done_o) & hold_done_n;
	initial begin
		cfg_clk = 1'b0;
		din = 1'b1;
		ticks = 0;
		hold_init_n = 1'b1;
		hold_done_n = 1'b1;
	end
	// Clock stands still between calls; odd delays keep edges off the system clock
	task send(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			din = v[i];
			#237 cfg_clk = 1'b1;
			ticks++;
			#400 cfg_clk = 1'b0;
			#163;
		end
		din = ~din;
	endtask
endmodule // fcs_cfg_source

/* bench/fcs_startup_ctrl_tb.sv */
`timescale 1ns/1ps
module fcs_startup_ctrl_tb;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} fcs_rd_t;
	localparam int LEN = 32 + fcs_pkg::FRAMES * (1 + fcs_pkg::FRAME_BITS + fcs_pkg::ERR_BITS);
	logic        clock;
	logic        nrst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        program_n;
	logic [2:0]  mode;
	logic        init_n_i;
	logic        init_n_o;
	logic        init_n_oe_n;
	logic        done_i;
	logic        done_o;
	logic        done_oe_n;
	logic        cfg_clock_i;
	logic        user_wakeup_clock;
	logic        din;
	logic        dout;
	logic        high_during_cfg;
	logic        low_during_cfg_n;
	logic        io_active;
	logic        gsr_active;
	logic        p_done;
	logic        p_io;
	logic        p_gsr;
	logic        p_init;
	fcs_rd_t     mon_r;
	fcs_rd_t     rd_q[$];
	logic [7:0]  ev_q[$];
	int          n_fail;
	int          check_count;
	int          base;
	int          uticks;
	int          ticks;

	fcs_startup_ctrl #(.POR_CYC(20)) dut (
		.CLOCK(clock), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .PROGRAM_N(program_n), .MODE(mode), .INIT_N_I(init_n_i),
		.INIT_N_O(init_n_o), .INIT_N_OE_N(init_n_oe_n), .DONE_I(done_i),
		.DONE_O(done_o), .DONE_OE_N(done_oe_n), .CFG_CLOCK_I(cfg_clock_i),
		.CFG_CLOCK_O(), .CFG_CLOCK_OE_N(), .USER_WAKEUP_CLOCK(user_wakeup_clock),
		.DIN(din), .DOUT(dout), .HIGH_DURING_CFG(high_during_cfg),
		.LOW_DURING_CFG_N(low_during_cfg_n), .IO_ACTIVE(io_active), .GSR_ACTIVE(gsr_active)
	);
	fcs_cfg_source src (
		.init_oe_n(init_n_oe_n), .init_o(init_n_o), .done_oe_n(done_oe_n), .done_o(done_o),
		.init_line(init_n_i), .done_line(done_i), .cfg_clk(cfg_clock_i), .din(din),
		.ticks(ticks)
	);

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 50);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
		rd_q.push_back({d & m, m, e});
		apb(1'b0, a, 32'h0);
	endtask

	// Event note: code in the upper nibble, stage distance from the first event below
	task ev(input logic [3:0] c);
		int t;
		logic [7:0] x;
		t = ticks + uticks;
		if (base < 0) base = t;
		x = (ev_q.size() > 0) ? ev_q.pop_front() : 8'h00;
		chk({24'h0, c, (x[3:0] == 4'hF) ? 4'hF : 4'(t - base)}, {24'h0, x});
	endtask

	// Stages waiting on the done wire get no fixed distance
	task plan_ev(input logic [7:0] c);
		logic [1:0] m;
		m = c[1:0];
		if (c[3:2] < m) m = c[3:2];
		if (c[5:4] < m) m = c[5:4];
		for (int s = 0; s < 4; s++) begin
			for (int k = 0; k < 3; k++) begin
				if (c[2*k+:2] == s) ev_q.push_back({4'(k + 1), (c[7] && s >= 2) ? 4'hF : 4'(s - m)});
			end
		end
	endtask

	always @(posedge clock) begin
		if (psel && penable && pready && !pwrite) begin
			mon_r = (rd_q.size() > 0) ? rd_q.pop_front() : '0;
			chk(prdata & mon_r.m, mon_r.d);
			chk(32'(pslverr), 32'(mon_r.e));
		end
		if (nrst) begin
			if (done_oe_n && !p_done) ev(4'h1);
			if (io_active && !p_io) ev(4'h2);
			if (!gsr_active && p_gsr) ev(4'h3);
			if (!init_n_oe_n && p_init && program_n) ev(4'h4);
		end
		p_done <= done_oe_n;
		p_io <= io_active;
		p_gsr <= gsr_active;
		p_init <= init_n_oe_n;
	end

	task uclk(input int n);
		repeat (n) begin
			repeat (4) @(posedge clock);
			user_wakeup_clock <= 1'b1;
			uticks++;
			repeat (4) @(posedge clock);
			user_wakeup_clock <= 1'b0;
		end
	endtask

	task cfg_run(input logic [7:0] c, input logic bad, input logic ucl);
		logic [15:0] dat;
		base = -1;
		@(posedge clock);
		program_n <= 1'b0;
		mode <= {2'($urandom()), 1'b1};
		src.hold_init_n = 1'b0;
		repeat (20) @(posedge clock);
		chk(32'({high_during_cfg, low_during_cfg_n, done_oe_n, init_n_oe_n, io_active,
			gsr_active}), 32'h21);
		apb(1'b1, fcs_pkg::OFS_CTRL, {24'h0, c});
		rd(fcs_pkg::OFS_CTRL, {24'h0, c}, 32'hFF, 1'b0);
		program_n <= 1'b1;
		repeat (300) @(posedge clock);
		rd(fcs_pkg::OFS_STATUS, 32'(fcs_pkg::ST_INIT_WAIT) << 4, 32'hF0, 1'b0);
		src.hold_init_n = 1'b1;
		repeat (600) @(posedge clock);
		rd(fcs_pkg::OFS_STATUS, {17'h0, mode, 4'h0, 4'(fcs_pkg::ST_CONFIG), 4'h0},
			32'h70F0, 1'b0);
		if (bad) ev_q.push_back(8'h40);
		else plan_ev(c);
		src.send(32'h7, 3);
		src.send(32'(fcs_pkg::PREAMBLE), 4);
		src.send(32'(LEN), fcs_pkg::LEN_BITS);
		for (int f = 0; f < fcs_pkg::FRAMES; f++) begin
			dat = 16'($urandom());
			src.send(32'h0, 1);
			if (f == 0) begin
				repeat (6) @(posedge clock);
				chk(32'(dout), 32'h1);
			end
			src.send(32'(dat), fcs_pkg::FRAME_BITS);
			src.send(32'(bad ? ~fcs_pkg::ERR_FIELD : fcs_pkg::ERR_FIELD), fcs_pkg::ERR_BITS);
			if (bad) break;
		end
		if (bad) begin
			src.send(32'hFF, 8);
			chk(32'({init_n_oe_n, done_oe_n, io_active}), 32'h0);
			$display("test done frame error");
			return;
		end
		src.send(32'h0, 1);
		// The source leaves its line inverted after a call; the chain output must track it
		repeat (10) @(posedge clock);
		chk(32'(dout), 32'(din));
		if (c[7]) src.hold_done_n = 1'b0;
		src.send(32'hFF, 8);
		if (ucl) begin
			chk(32'({done_oe_n, io_active, gsr_active}), 32'h1);
			uclk(8);
		end
		if (c[7]) begin
			chk(32'(gsr_active), 32'h1);
			src.hold_done_n = 1'b1;
			src.send(32'hF, 4);
		end
		repeat (10) @(posedge clock);
		chk(32'({io_active, gsr_active, done_oe_n, high_during_cfg, low_during_cfg_n}),
			32'h15);
		rd(fcs_pkg::OFS_LENGTH, LEN, 32'hFFFFFF, 1'b0);
		$display("test done ctrl %h", c);
	endtask

	initial begin
		repeat (80000) @(posedge clock);
		n_fail++;
		complete_run;
	end

	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		program_n = 1'b1;
		mode = 3'h1;
		user_wakeup_clock = 1'b0;
		n_fail = 0;
		check_count = 0;
		uticks = 0;
		base = -1;
		void'($urandom(32'h31BB));
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		rd(fcs_pkg::OFS_CTRL, {24'h0, fcs_pkg::CTRL_RST}, 32'hFFFFFFFF, 1'b0);
		rd(12'h010, 32'h0, 32'hFFFFFFFF, 1'b1);
		apb(1'b1, 12'h010, 32'hFF);
		rd(fcs_pkg::OFS_CTRL, {24'h0, fcs_pkg::CTRL_RST}, 32'hFF, 1'b0);
		$display("test done registers");
		cfg_run(8'h24, 1'b0, 1'b0);
		cfg_run(8'h12, 1'b0, 1'b0);
		cfg_run(8'h24, 1'b1, 1'b0);
		cfg_run(8'hA4, 1'b0, 1'b0);
		cfg_run(8'h64, 1'b0, 1'b1);
		cfg_run({2'b00, 6'($urandom())}, 1'b0, 1'b0);
		complete_run;
	end
endmodule // fcs_startup_ctrl_tb
